//--- hw/reset_cause_flag_register.sv
`timescale 1ns/1ns
`include "reset_cause_params.svh"
module reset_cause_flag_register (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire reset_cause_pkg::reset_events_t reset_events,
   input  wire logic                          external_reset_pin_n,
   input  wire logic                          stack_reset_enable,
   output logic      [7:0]                    reset_cause_flags,
   output logic                               irq
);

   reset_cause_pkg::block_state_t  s;
   reset_cause_pkg::block_state_t  next_s;
   reset_cause_pkg::reset_events_t ev;
   logic                           pin_event;
   logic [2:0]                     wr_sel;
   logic [2:0]                     rd_sel;
   logic                           wr_take;
   logic [7:0]                     set_vec;

   // one-hot select: bit 0 flags, bit 1 irq status, bit 2 irq mask
   function automatic logic [2:0] decode(input logic [11:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      case (addr)
         `RC_ADDR_FLAGS: begin
            sel = 3'h1;
         end
         `RC_ADDR_IRQ_STATUS: begin
            sel = 3'h2;
         end
         `RC_ADDR_IRQ_MASK: begin
            sel = 3'h4;
         end
         default: begin
            sel = 3'h0;
         end
      endcase
      return sel;
   endfunction

   reset_pin_sync u_pin_sync (
      .pclk                 (pclk),
      .presetn              (presetn),
      .external_reset_pin_n (external_reset_pin_n),
      .asserted             (pin_event)
   );

   // stack events only count while stack resets are enabled
   always_comb begin
      ev         = reset_events;
      ev.stk_ovf = reset_events.stk_ovf & stack_reset_enable;
      ev.stk_unf = reset_events.stk_unf & stack_reset_enable;
   end

   // event vector in the same layout as the flag register
   always_comb begin
      set_vec                = 8'h00;
      set_vec[`RC_BIT_OVF]   = ev.stk_ovf;
      set_vec[`RC_BIT_UNF]   = ev.stk_unf;
      set_vec[`RC_BIT_WDT]   = ev.wdt;
      set_vec[`RC_BIT_PIN]   = pin_event;
      set_vec[`RC_BIT_INSTR] = ev.instr;
      set_vec[`RC_BIT_POR]   = ev.por;
      set_vec[`RC_BIT_BROWNOUT] = ev.brownout;
   end

   assign wr_sel  = decode(paddr);
   assign rd_sel  = wr_sel;
   // a write lands only at the access edge with pready high
   assign wr_take = psel & penable & pwrite & s.pready
                    & (s.bus == reset_cause_pkg::bus_answer);

   always_comb begin
      next_s = s;

      // software write first; hardware below overrides it
      if (wr_take && wr_sel[0]) begin
         next_s.flags = pwdata[7:0] & `RC_IMPL_MASK;
      end

      if (ev.por) begin
         next_s.flags = `RC_FLAGS_RESET;
      end else if (ev.brownout) begin
         // power-on bit is left alone by a brown-out
         next_s.flags[`RC_BIT_OVF]   = 1'b0;
         next_s.flags[`RC_BIT_UNF]   = 1'b0;
         next_s.flags[`RC_BIT_WDT]   = 1'b1;
         next_s.flags[`RC_BIT_PIN]   = 1'b1;
         next_s.flags[`RC_BIT_INSTR] = 1'b1;
         next_s.flags[`RC_BIT_BROWNOUT] = 1'b0;
      end else begin
         // only the bit of each cause moves; all else stays
         if (ev.wdt) begin
            next_s.flags[`RC_BIT_WDT] = 1'b0;
         end
         if (pin_event) begin
            next_s.flags[`RC_BIT_PIN] = 1'b0;
         end
         if (ev.instr) begin
            next_s.flags[`RC_BIT_INSTR] = 1'b0;
         end
         if (ev.stk_ovf) begin
            next_s.flags[`RC_BIT_OVF] = 1'b1;
         end
         if (ev.stk_unf) begin
            next_s.flags[`RC_BIT_UNF] = 1'b1;
         end
      end

      // write-one-to-clear; a set in the same cycle wins
      if (wr_take && wr_sel[1]) begin
         next_s.irq_status = s.irq_status & ~pwdata[7:0];
      end
      next_s.irq_status = (next_s.irq_status | set_vec) & `RC_IMPL_MASK;

      if (wr_take && wr_sel[2]) begin
         next_s.irq_mask = pwdata[7:0] & `RC_IMPL_MASK;
      end

      next_s.irq = |(next_s.irq_status & next_s.irq_mask);

      // read data is captured in the setup cycle, answered one cycle later
      case (s.bus)
         reset_cause_pkg::bus_idle: begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
            if (psel && !penable) begin
               next_s.bus     = reset_cause_pkg::bus_answer;
               next_s.pready  = 1'b1;
               next_s.pslverr = ~|rd_sel;
               next_s.prdata  = 32'h0000_0000;
               if (!pwrite) begin
                  case (rd_sel)
                     3'h1: begin
                        next_s.prdata[7:0] = s.flags;
                     end
                     3'h2: begin
                        next_s.prdata[7:0] = s.irq_status;
                     end
                     3'h4: begin
                        next_s.prdata[7:0] = s.irq_mask;
                     end
                     default: begin
                        next_s.prdata = 32'h0000_0000;
                     end
                  endcase
               end
            end
         end
         reset_cause_pkg::bus_answer: begin
            // an abandoned transfer also returns to idle
            if (!psel || penable) begin
               next_s.bus     = reset_cause_pkg::bus_idle;
               next_s.pready  = 1'b0;
               next_s.pslverr = 1'b0;
               next_s.prdata  = 32'h0000_0000;
            end
         end
         default: begin
            next_s.bus     = reset_cause_pkg::bus_idle;
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
         end
      endcase
   end

   // presetn stands for power-on: flags come up as after a power-on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.bus        <= reset_cause_pkg::bus_idle;
         s.flags      <= `RC_FLAGS_RESET;
         s.irq_status <= `RC_STATUS_RESET;
         s.irq_mask   <= `RC_MASK_RESET;
         s.irq        <= 1'b0;
         s.prdata     <= 32'h0000_0000;
         s.pready     <= 1'b0;
         s.pslverr    <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign prdata            = s.prdata;
   assign pready            = s.pready;
   assign pslverr           = s.pslverr;
   assign reset_cause_flags = s.flags;
   assign irq               = s.irq;

   logic hw_quiet;
   logic flag_write;

   assign hw_quiet   = ~|set_vec;
   assign flag_write = wr_take & wr_sel[0];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_por_values;
      ev.por |=> reset_cause_flags == `RC_FLAGS_RESET;
   endproperty
   a_por_values: assert property (p_por_values)
      else $error("power-on did not load flag defaults");

   property p_brownout_values;
      ev.brownout && !ev.por |=> reset_cause_flags[7:6] == 2'b00
         && reset_cause_flags[4:2] == 3'b111 && !reset_cause_flags[0]
         && reset_cause_flags[1] == ($past(flag_write) ? $past(pwdata[1])
                                                       : $past(reset_cause_flags[1]));
   endproperty
   a_brownout_values: assert property (p_brownout_values)
      else $error("brown-out flag update wrong");

   property p_wdt_clear;
      ev.wdt && !ev.por && !ev.brownout |=> !reset_cause_flags[`RC_BIT_WDT];
   endproperty
   a_wdt_clear: assert property (p_wdt_clear)
      else $error("watchdog flag not cleared");

   property p_pin_clear;
      $fell(external_reset_pin_n) ##3 !ev.por && !ev.brownout
         |=> !reset_cause_flags[`RC_BIT_PIN];
   endproperty
   a_pin_clear: assert property (p_pin_clear)
      else $error("pin reset flag not cleared");

   property p_instr_clear;
      ev.instr && !ev.por && !ev.brownout |=> !reset_cause_flags[`RC_BIT_INSTR];
   endproperty
   a_instr_clear: assert property (p_instr_clear)
      else $error("instruction reset flag not cleared");

   property p_ovf_set;
      reset_events.stk_ovf && stack_reset_enable && !ev.por && !ev.brownout
         |=> reset_cause_flags[`RC_BIT_OVF];
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow flag not set");

   property p_unf_set;
      reset_events.stk_unf && stack_reset_enable && !ev.por && !ev.brownout
         |=> reset_cause_flags[`RC_BIT_UNF];
   endproperty
   a_unf_set: assert property (p_unf_set)
      else $error("underflow flag not set");

   property p_stack_gated;
      !stack_reset_enable && !flag_write && !ev.por && !ev.brownout
         |=> $stable(reset_cause_flags[7:6]);
   endproperty
   a_stack_gated: assert property (p_stack_gated)
      else $error("stack flag moved while stack resets disabled");

   property p_gap_zero;
      !reset_cause_flags[`RC_BIT_GAP] && !prdata[`RC_BIT_GAP] && prdata[31:8] == 24'h0;
   endproperty
   a_gap_zero: assert property (p_gap_zero)
      else $error("unimplemented bit read as one");

   property p_hold;
      hw_quiet && !flag_write |=> $stable(reset_cause_flags);
   endproperty
   a_hold: assert property (p_hold)
      else $error("flags changed with no cause");

   property p_write_lands;
      flag_write && hw_quiet |=> reset_cause_flags == ($past(pwdata[7:0]) & 8'hdf);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("flag write not stored");

   property p_hw_wins;
      flag_write && ev.wdt && !ev.por && !ev.brownout && pwdata[`RC_BIT_WDT]
         |=> !reset_cause_flags[`RC_BIT_WDT];
   endproperty
   a_hw_wins: assert property (p_hw_wins)
      else $error("write beat hardware update");

   property p_irq_level;
      ##1 irq == |(s.irq_status & s.irq_mask);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output disagrees with status and mask");

   property p_answer;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_answer: assert property (p_answer)
      else $error("bus answer not one cycle after setup");

endmodule

//--- hw/reset_cause_params.svh
// What this block does
// - power-on and brown-out load several flags; any other reset updates only the flag of its own cause, others keep value
// - apart from power-on and brown-out, hardware never returns a flag to inactive; software does that
// - software may write flags active; stored, readable, no reset caused
// - bit 7 stack overflow flag, set by hardware, zero after power-on/brown-out
// - bit 6 stack underflow flag, set by hardware, zero after power-on/brown-out
// - bit 5 unimplemented, reads zero, writes ignored
// - bit 4 watchdog flag, active low, cleared on watchdog reset
// - bit 3 external pin flag, active low, cleared on pin reset
// - bit 2 reset instruction flag, active low, cleared on instruction reset
// - bit 1 power-on flag, zero on power-on only, software sets it
// - bit 0 brown-out flag, zero on brown-out, software sets it
// - stack resets set their flags only while stack reset enable is set
`ifndef RESET_CAUSE_PARAMS_SVH
`define RESET_CAUSE_PARAMS_SVH

`define RC_ADDR_FLAGS      12'h000
`define RC_ADDR_IRQ_STATUS 12'h004
`define RC_ADDR_IRQ_MASK   12'h008

`define RC_BIT_OVF   7
`define RC_BIT_UNF   6
`define RC_BIT_GAP   5
`define RC_BIT_WDT   4
`define RC_BIT_PIN   3
`define RC_BIT_INSTR 2
`define RC_BIT_POR   1
`define RC_BIT_BROWNOUT 0

`define RC_IMPL_MASK    8'hdf
`define RC_FLAGS_RESET  8'h1c
`define RC_STATUS_RESET 8'h00
`define RC_MASK_RESET   8'h00

`endif

//--- hw/reset_cause_pkg.sv
package reset_cause_pkg;

   typedef struct packed {
      logic por;
      logic brownout;
      logic instr;
      logic wdt;
      logic stk_ovf;
      logic stk_unf;
   } reset_events_t;

   typedef enum logic [1:0] {
      bus_idle   = 2'b01,
      bus_answer = 2'b10
   } bus_state_t;

   typedef struct packed {
      bus_state_t  bus;
      logic [7:0]  flags;
      logic [7:0]  irq_status;
      logic [7:0]  irq_mask;
      logic        irq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } block_state_t;

   typedef struct packed {
      logic meta;
      logic level;
      logic last;
      logic pulse;
   } pin_sync_t;

endpackage

//--- hw/reset_pin_sync.sv
`timescale 1ns/1ns
module reset_pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic external_reset_pin_n,
   output logic      asserted
);

   reset_cause_pkg::pin_sync_t s;
   reset_cause_pkg::pin_sync_t next_s;

   // edge detect compares the second stage with the third, never looks at meta
   always_comb begin
      next_s       = s;
      next_s.meta  = external_reset_pin_n;
      next_s.level = s.meta;
      next_s.last  = s.level;
      next_s.pulse = s.last & ~s.level;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{meta: 1'b1, level: 1'b1, last: 1'b1, pulse: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign asserted = s.pulse;

endmodule

//--- testbench/reset_cause_flag_register_bench.sv
`timescale 1ns/1ns
`include "reset_cause_params.svh"
module reset_cause_flag_register_bench;
   logic                           pclk;
   logic                           presetn;
   logic                           psel;
   logic                           penable;
   logic                           pwrite;
   logic [11:0]                    paddr;
   logic [31:0]                    pwdata;
   logic [31:0]                    prdata;
   logic                           pready;
   logic                           pslverr;
   reset_cause_pkg::reset_events_t ev;
   logic                           pin_n;
   logic                           stk_en;
   logic [7:0]                     flags;
   logic                           irq;
   logic [31:0]                    rd;
   logic                           err;
   int                             miscompares;
   int                             checks;

   reset_cause_flag_register dut (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .reset_events         (ev),
      .external_reset_pin_n (pin_n),
      .stack_reset_enable   (stk_en),
      .reset_cause_flags    (flags),
      .irq                  (irq)
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   // one transfer plus an idle edge, so back-to-back calls never double-drive psel
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input reset_cause_pkg::reset_events_t e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      ev <= e;
      n = 0;
      do begin
         @(posedge pclk);
         ev <= '0;
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         finish_test();
      end
      @(posedge pclk);
   endtask

   task automatic pulse(input reset_cause_pkg::reset_events_t e);
      ev <= e;
      @(posedge pclk);
      ev <= '0;
      @(posedge pclk);
   endtask

   function automatic logic [7:0] next_flags(input logic [7:0] f,
                                              input reset_cause_pkg::reset_events_t e,
                                              input logic en);
      logic [7:0] n;
      n = f;
      if (e.por) begin
         n = 8'h1c;
      end else if (e.brownout) begin
         n = {3'b000, 3'b111, f[1], 1'b0};
      end else begin
         if (e.instr) n[2] = 1'b0;
         if (e.wdt) n[4] = 1'b0;
         if (e.stk_ovf && en) n[7] = 1'b1;
         if (e.stk_unf && en) n[6] = 1'b1;
      end
      return n;
   endfunction

   initial begin
      logic [7:0]                     d;
      reset_cause_pkg::reset_events_t e;
      logic                           en;
      int                             n;
      miscompares = 0;
      checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ev = '0;
      pin_n = 1'b1;
      stk_en = 1'b1;
      void'($urandom(32'h3ed63b76));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("flags after reset", flags, 8'h1c);
      apb(1'b0, `RC_ADDR_FLAGS, 32'h0, '0);
      check("flags read", rd, 32'h1c);
      check("flags read err", err, 1'b0);
      // software writes, corners first; gap bit must never stick
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         apb(1'b1, `RC_ADDR_FLAGS, {24'h0, d}, '0);
         check("flags written", flags, d & 8'hdf);
         apb(1'b0, `RC_ADDR_FLAGS, 32'h0, '0);
         check("flags readback", rd, {24'h0, d & 8'hdf});
         apb(1'b0, `RC_ADDR_IRQ_STATUS, 32'h0, '0);
         check("no reset action on write", rd, 32'h0);
      end
      // each cause from a random start, stack causes with and without enable
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom) & 8'hdf;
         en = (i < 6);
         e = reset_cause_pkg::reset_events_t'(6'h01 << (i % 6));
         stk_en <= en;
         apb(1'b1, `RC_ADDR_FLAGS, {24'h0, d}, '0);
         pulse(e);
         check("flags after event", flags, next_flags(d, e, en));
         repeat (3) @(posedge pclk);
         check("flags kept", flags, next_flags(d, e, en));
      end
      stk_en <= 1'b1;
      // write and event on the same edge
      apb(1'b1, `RC_ADDR_FLAGS, 32'hff, 6'b000100);
      check("wdt beats write", flags, 8'hcf);
      apb(1'b1, `RC_ADDR_FLAGS, 32'h00, 6'b000010);
      check("ovf beats write", flags, 8'h80);
      // pin reset through the synchroniser
      apb(1'b1, `RC_ADDR_FLAGS, 32'hdf, '0);
      pin_n <= 1'b0;
      n = 0;
      while (flags[3] !== 1'b0 && n < 12) begin
         @(posedge pclk);
         n++;
      end
      check("pin flag", flags, 8'hd7);
      pin_n <= 1'b1;
      repeat (10) @(posedge pclk);
      check("pin flag held", flags, 8'hd7);
      // interrupt raise, mask, clear
      apb(1'b1, `RC_ADDR_IRQ_STATUS, 32'hff, '0);
      apb(1'b1, `RC_ADDR_IRQ_MASK, 32'h10, '0);
      check("irq idle", irq, 1'b0);
      pulse(6'b000100);
      pulse(6'b001000);
      check("irq raised", irq, 1'b1);
      apb(1'b0, `RC_ADDR_IRQ_STATUS, 32'h0, '0);
      check("status", rd, 32'h14);
      apb(1'b1, `RC_ADDR_IRQ_MASK, 32'h00, '0);
      @(posedge pclk);
      check("irq masked", irq, 1'b0);
      apb(1'b1, `RC_ADDR_IRQ_MASK, 32'h10, '0);
      @(posedge pclk);
      check("irq unmasked", irq, 1'b1);
      apb(1'b1, `RC_ADDR_IRQ_STATUS, 32'h10, '0);
      @(posedge pclk);
      check("irq cleared", irq, 1'b0);
      apb(1'b0, `RC_ADDR_IRQ_STATUS, 32'h0, '0);
      check("status after clear", rd, 32'h04);
      // unmapped place
      d = flags;
      apb(1'b1, 12'h00c, 32'hff, '0);
      check("unmapped write err", err, 1'b1);
      apb(1'b0, 12'h00c, 32'h0, '0);
      check("unmapped read err", err, 1'b1);
      check("unmapped read data", rd, 32'h0);
      check("flags untouched", flags, d);
      // reset in mid-run reloads the power-on value
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("flags after second reset", flags, 8'h1c);
      finish_test();
   end
endmodule
